// *** rtl/tivm_vector_map.sv ***
//------------------------------------------------------------------------------
// Purpose: Trap and peripheral vector mapping with single merged CPU request
// Assumes: Inputs synchronous to i_sys_clk; CPU clears flags by pulses
// Notes:   Winner and fetch address are registered, one cycle behind flags
//------------------------------------------------------------------------------
`timescale 1ns/100ps

module tivm_vector_map
	import tivm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire tivm_trap_ev_t i_trap_ev,
	input wire logic [NIRQ-1:0] i_irq_req,
	input wire logic [NIRQ-1:0] i_request_enable,
	input wire logic [NIRQ*PFIELD_W-1:0] i_priority_regs,
	input wire logic [NIRQ-1:0] i_flag_clr,
	input wire logic [15:0] i_intr_ctrl_second,
	input wire logic [ADDR_W-1:0] i_alt_table_base,
	input wire logic [15:0] i_intr_ctrl_first_clr,
	input wire logic [NTRAP-1:0] i_trap_clr,
	input wire logic [15:0] i_intr_ctrl_fourth_clr,
	input wire logic [CPRIO_W-1:0] i_cpu_prio,
	output logic [NIRQ-1:0] o_request_flags,
	output logic [15:0] o_intr_ctrl_first,
	output logic [15:0] o_intr_ctrl_fourth,
	output logic [NTRAP-1:0] o_trap_pending,
	output logic o_cpu_req,
	output logic o_cpu_req_trap,
	output logic [VEC_W-1:0] o_vector_num,
	output logic [ADDR_W-1:0] o_vector_addr,
	output logic [CPRIO_W-1:0] o_vector_prio
);

	//--------------------------------------------------------------------------
	// Reset release
	//--------------------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_b;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_b = rst_sync_reg;

	//--------------------------------------------------------------------------
	// Peripheral request flags
	//--------------------------------------------------------------------------
	// Set wins over clear so a request in the clearing cycle survives
	logic [NIRQ-1:0] flag_reg;

	genvar gi;
	generate
		for (gi = 0; gi < NIRQ; gi++) begin : g_flag
			always_ff @(posedge i_sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					flag_reg[gi] <= 1'b0;
				end else if (!IRQ_IMPL[gi]) begin
					flag_reg[gi] <= 1'b0;
				end else if (i_irq_req[gi]) begin
					flag_reg[gi] <= 1'b1;
				end else if (i_flag_clr[gi]) begin
					flag_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	//--------------------------------------------------------------------------
	// Trap flags
	//--------------------------------------------------------------------------
	logic [15:0] first_reg;
	logic [15:0] fourth_reg;
	logic [NTRAP-1:0] trap_reg;
	logic soft_ev;
	logic [NTRAP-1:0] trap_set;

	// The soft hard trap only counts while its enable is set
	assign soft_ev = i_trap_ev.soft_generic_hard_trap
		&& i_intr_ctrl_second[SECOND_SOFT_EN_BIT];

	always_comb begin
		trap_set = '0;
		trap_set[TRAP_OSC_FAIL] = i_trap_ev.osc_fail;
		trap_set[TRAP_ADDR_ERR] = i_trap_ev.addr_err;
		trap_set[TRAP_HARD_ERR] = i_trap_ev.ecc_double_bit_error
			|| soft_ev;
		trap_set[TRAP_STACK_ERR] = i_trap_ev.stack_err;
		trap_set[TRAP_MATH_ERR] = i_trap_ev.divide_by_zero_error;
	end

	always_ff @(posedge i_sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			trap_reg <= '0;
		end else begin
			trap_reg <= trap_set | (trap_reg & ~i_trap_clr);
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			first_reg <= '0;
		end else begin
			first_reg[FIRST_OSC_FAIL_BIT] <= i_trap_ev.osc_fail
				|| (first_reg[FIRST_OSC_FAIL_BIT]
				&& !i_intr_ctrl_first_clr[FIRST_OSC_FAIL_BIT]);
			first_reg[FIRST_MATH_BIT] <= i_trap_ev.divide_by_zero_error
				|| (first_reg[FIRST_MATH_BIT]
				&& !i_intr_ctrl_first_clr[FIRST_MATH_BIT]);
		end
	end

	always_ff @(posedge i_sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fourth_reg <= '0;
		end else begin
			fourth_reg[FOURTH_ECC_BIT] <= i_trap_ev.ecc_double_bit_error
				|| (fourth_reg[FOURTH_ECC_BIT]
				&& !i_intr_ctrl_fourth_clr[FOURTH_ECC_BIT]);
			fourth_reg[FOURTH_SOFT_BIT] <= soft_ev
				|| (fourth_reg[FOURTH_SOFT_BIT]
				&& !i_intr_ctrl_fourth_clr[FOURTH_SOFT_BIT]);
		end
	end

	//--------------------------------------------------------------------------
	// Arbitration
	//--------------------------------------------------------------------------
	// Traps scan from vector 0 so the first hit is the highest fixed level;
	// peripherals need a strictly higher level to replace, so the lower
	// IRQ keeps a tie. A user level of zero disables the source.
	tivm_grant_t win;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] ofs;
	logic [PRIO_W-1:0] uprio;

	always_comb begin
		win = '0;
		uprio = '0;
		for (int t = 0; t < NTRAP; t++) begin
			if (!win.valid && trap_reg[t] && TRAP_PRIO[t] != 4'h0) begin
				win.valid = 1'b1;
				win.is_trap = 1'b1;
				win.vector = VEC_W'(t);
				win.prio = TRAP_PRIO[t];
			end
		end
		if (!win.valid) begin
			for (int n = 0; n < NIRQ; n++) begin
				uprio = i_priority_regs[n*PFIELD_W +: PRIO_W];
				if (flag_reg[n] && i_request_enable[n] && uprio != 3'h0
					&& {1'b0, uprio} > win.prio) begin
					win.valid = 1'b1;
					win.vector = IRQ_VECTOR_OFS + VEC_W'(n);
					win.prio = {1'b0, uprio};
				end
			end
		end
		if (win.prio <= i_cpu_prio) begin
			win.valid = 1'b0;
		end
	end

	//--------------------------------------------------------------------------
	// Fetch address
	//--------------------------------------------------------------------------
	always_comb begin
		if (win.is_trap) begin
			ofs = TRAP_TABLE_OFS + {16'h0000, win.vector, 1'b0};
		end else begin
			ofs = IRQ_TABLE_OFS
				+ {16'h0000, win.vector - IRQ_VECTOR_OFS, 1'b0};
		end
		// Alternate table mirrors the primary layout from its own base
		base = i_intr_ctrl_second[SECOND_ALT_EN_BIT]
			? i_alt_table_base : '0;
	end

	always_ff @(posedge i_sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_cpu_req <= 1'b0;
			o_cpu_req_trap <= 1'b0;
			o_vector_num <= '0;
			o_vector_addr <= '0;
			o_vector_prio <= '0;
		end else begin
			o_cpu_req <= win.valid;
			o_cpu_req_trap <= win.valid && win.is_trap;
			o_vector_num <= win.vector;
			o_vector_addr <= base + ofs;
			o_vector_prio <= win.prio;
		end
	end

	//--------------------------------------------------------------------------
	// Status outputs
	//--------------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			o_request_flags <= '0;
			o_intr_ctrl_first <= '0;
			o_intr_ctrl_fourth <= '0;
			o_trap_pending <= '0;
		end else begin
			o_request_flags <= flag_reg;
			o_intr_ctrl_first <= first_reg;
			o_intr_ctrl_fourth <= fourth_reg;
			o_trap_pending <= trap_reg;
		end
	end

endmodule : tivm_vector_map

// *** rtl/tivm_pkg.sv ***
//------------------------------------------------------------------------------
// Purpose: Constants and types for the trap and interrupt vector map
// Assumes: One 200 MHz system clock; requests are synchronous pulses or levels
// Notes:   IRQ flag, enable and priority words are flattened into vectors
//------------------------------------------------------------------------------
// How it works
// - ECC double-bit error raises vector 2 trap, priority 13
// - Soft generic hard trap shares vector 2, gated
// - Divide-by-zero raises math trap vector 4, priority 11
// - Alternate vector equals alternate base plus primary offset
// - DMA0 is IRQ 4, address 1Ch, field PRIORITY_REG_ONE low
// - DMA1 is IRQ 14, address 30h, priority reg 3
// - DMA2 is IRQ 24, address 44h, priority reg 6
// - DMA3 is IRQ 36, address 5Ch, priority reg 9
// - Alternate enable redirects every vector fetch
// - Equal priority ties go to lower table address
// - Seven user levels; traps outrank all of them
package tivm_pkg;

	//--------------------------------------------------------------------------
	// Sizes
	//--------------------------------------------------------------------------
	localparam int NIRQ = 48;
	localparam int NTRAP = 8;
	localparam int PRIO_W = 3;
	localparam int PFIELD_W = 4;
	localparam int ADDR_W = 24;
	localparam int VEC_W = 7;
	localparam int CPRIO_W = 4;

	//--------------------------------------------------------------------------
	// Table layout
	//--------------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] TRAP_TABLE_OFS = 24'h000004;
	localparam logic [ADDR_W-1:0] IRQ_TABLE_OFS = 24'h000014;
	localparam logic [VEC_W-1:0] IRQ_VECTOR_OFS = 7'h08;

	// Trap vector numbers
	localparam logic [2:0] TRAP_OSC_FAIL = 3'h0;
	localparam logic [2:0] TRAP_ADDR_ERR = 3'h1;
	localparam logic [2:0] TRAP_HARD_ERR = 3'h2;
	localparam logic [2:0] TRAP_STACK_ERR = 3'h3;
	localparam logic [2:0] TRAP_MATH_ERR = 3'h4;

	// Fixed trap priorities, indexed by trap vector; zero marks reserved
	localparam logic [CPRIO_W-1:0] TRAP_PRIO [NTRAP] = '{
		4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'h0, 4'h0, 4'h0};

	// Bit positions in the control words
	localparam int FIRST_OSC_FAIL_BIT = 1;
	localparam int FIRST_MATH_BIT = 3;
	localparam int FOURTH_ECC_BIT = 1;
	localparam int FOURTH_SOFT_BIT = 0;
	localparam int SECOND_SOFT_EN_BIT = 13;
	localparam int SECOND_ALT_EN_BIT = 8;

	// IRQs that have a source; the rest are reserved slots
	localparam logic [NIRQ-1:0] IRQ_IMPL = 48'h7833_E31F_FFFF;

	//--------------------------------------------------------------------------
	// Types
	//--------------------------------------------------------------------------
	typedef struct packed {
		logic osc_fail;
		logic addr_err;
		logic ecc_double_bit_error;
		logic soft_generic_hard_trap;
		logic stack_err;
		logic divide_by_zero_error;
	} tivm_trap_ev_t;

	typedef struct packed {
		logic valid;
		logic is_trap;
		logic [VEC_W-1:0] vector;
		logic [ADDR_W-1:0] addr;
		logic [CPRIO_W-1:0] prio;
	} tivm_grant_t;

endpackage : tivm_pkg

// *** test/tivm_monitor.sv ***
// Purpose: Port checks on the vector map
// Assumes: One clock, reset active low
// Notes:   Bound to every vector map
`timescale 1ns/100ps
module tivm_monitor
	import tivm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire tivm_trap_ev_t i_trap_ev,
	input wire logic [NIRQ-1:0] i_irq_req,
	input wire logic [15:0] i_intr_ctrl_second,
	input wire logic [ADDR_W-1:0] i_alt_table_base,
	input wire logic [NIRQ-1:0] o_request_flags,
	input wire logic [15:0] o_intr_ctrl_first,
	input wire logic [15:0] o_intr_ctrl_fourth,
	input wire logic [NTRAP-1:0] o_trap_pending,
	input wire logic o_cpu_req,
	input wire logic o_cpu_req_trap,
	input wire logic [VEC_W-1:0] o_vector_num,
	input wire logic [ADDR_W-1:0] o_vector_addr,
	input wire logic [CPRIO_W-1:0] o_vector_prio
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	a_fetch_addr: assert property (o_cpu_req |->
		o_vector_addr == (i_intr_ctrl_second[8] ? i_alt_table_base : 24'h0)
		+ {16'h0, o_vector_num, 1'b0} + 24'h4) else $error("bad address");
	a_trap_prio: assert property (o_cpu_req && o_cpu_req_trap |->
		o_vector_prio == 4'hF - {1'b0, o_vector_num[2:0]})
		else $error("bad trap priority");
	a_user_level: assert property (o_cpu_req && !o_cpu_req_trap |->
		o_vector_prio inside {[1:7]} && o_vector_num >= 7'h08)
		else $error("bad user level");
	a_div_trap: assert property (i_trap_ev.divide_by_zero_error |->
		##2 o_intr_ctrl_first[3] && o_trap_pending[4]) else $error("no div");
	a_ecc_trap: assert property (i_trap_ev.ecc_double_bit_error |->
		##2 o_intr_ctrl_fourth[1] && o_trap_pending[2]) else $error("no ecc");
	a_soft_set: assert property (i_trap_ev.soft_generic_hard_trap &&
		i_intr_ctrl_second[13] |-> ##2 o_intr_ctrl_fourth[0])
		else $error("no soft trap");
	a_soft_gate: assert property ($rose(o_intr_ctrl_fourth[0]) |->
		$past(i_intr_ctrl_second[13], 2)) else $error("soft trap ungated");
	a_reserved_quiet: assert property (
		(o_request_flags & ~IRQ_IMPL) == '0) else $error("reserved flag");
	a_dma_flag: assert property (i_irq_req[24] |->
		##2 o_request_flags[24]) else $error("no dma flag");
	c_trap: cover property (o_cpu_req && o_cpu_req_trap);
	c_alt: cover property (o_cpu_req && i_intr_ctrl_second[8]);
	c_tie: cover property (o_cpu_req && o_vector_num == 7'h0D);
endmodule : tivm_monitor
bind tivm_vector_map tivm_monitor tivm_monitor_i (.*);

// *** test/tivm_cpu_model.sv ***
// Purpose: CPU side that takes requests and clears the source
// Assumes: One clear pulse per taken request
// Notes:   Stall input holds off service
`timescale 1ns/100ps
module tivm_cpu_model
	import tivm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_stall,
	input wire logic i_req,
	input wire logic i_trap,
	input wire logic [VEC_W-1:0] i_vec,
	output logic [NIRQ-1:0] o_flag_clr,
	output logic [NTRAP-1:0] o_trap_clr
);
	logic [1:0] wait_reg;
	// Hold-off covers the two cycles the request lingers after a clear
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wait_reg <= 2'h0;
			o_flag_clr <= '0;
			o_trap_clr <= '0;
		end else begin
			o_flag_clr <= '0;
			o_trap_clr <= '0;
			if (wait_reg != 2'h0) begin
				wait_reg <= wait_reg - 2'h1;
			end else if (i_req && !i_stall) begin
				wait_reg <= 2'h3;
				if (i_trap) begin
					o_trap_clr <= NTRAP'(1) << i_vec[2:0];
				end else begin
					o_flag_clr <= NIRQ'(1) << (i_vec - IRQ_VECTOR_OFS);
				end
			end
		end
	end
endmodule : tivm_cpu_model

// *** test/test_trap_and_interrupt_vector_map.sv ***
// Purpose: Self-checking bench for the vector map
// Assumes: CPU model clears what it is granted
// Notes:   CPU priority held at zero except during the masked check at level 1
`timescale 1ns/100ps
module test_trap_and_interrupt_vector_map;
	import tivm_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic stall = 1'b0;
	tivm_trap_ev_t i_trap_ev = '0;
	logic [NIRQ-1:0] i_irq_req = '0, i_request_enable = '1, i_flag_clr;
	logic [NIRQ*PFIELD_W-1:0] i_priority_regs = '0;
	logic [15:0] i_intr_ctrl_second = '0, i_intr_ctrl_first_clr = '0;
	logic [15:0] i_intr_ctrl_fourth_clr = '0, o_intr_ctrl_first;
	logic [15:0] o_intr_ctrl_fourth;
	logic [ADDR_W-1:0] i_alt_table_base = 24'h00A000, o_vector_addr;
	logic [NTRAP-1:0] i_trap_clr, o_trap_pending;
	logic [CPRIO_W-1:0] i_cpu_prio = '0, o_vector_prio;
	logic [NIRQ-1:0] o_request_flags;
	logic o_cpu_req, o_cpu_req_trap;
	logic [VEC_W-1:0] o_vector_num;
	int bad_count = 0, comparisons = 0, cyc = 0;
	tivm_vector_map tivm_vector_map_i (.*);
	tivm_cpu_model tivm_cpu_model_i (.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b), .i_stall(stall), .i_req(o_cpu_req),
		.i_trap(o_cpu_req_trap), .i_vec(o_vector_num),
		.o_flag_clr(i_flag_clr), .o_trap_clr(i_trap_clr));
	always #2.5 i_sys_clk = ~i_sys_clk;
	task automatic chk(string n, logic [23:0] e, logic [23:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic chkv(logic [23:0] v, logic [23:0] a, logic [23:0] p);
		chk("vector", v, o_vector_num);
		chk("address", a, o_vector_addr);
		chk("priority", p, o_vector_prio);
		chk("request", 1, o_cpu_req);
		chk("trap kind", 24'(v < 24'h8), o_cpu_req_trap);
	endtask : chkv
	// Request sampled one edge after launch, outputs one edge later
	task automatic fire(tivm_trap_ev_t t, logic [NIRQ-1:0] r,
		logic [15:0] c);
		@(posedge i_sys_clk);
		i_trap_ev <= t;
		i_irq_req <= r;
		i_intr_ctrl_second <= c;
		@(posedge i_sys_clk);
		i_trap_ev <= '0;
		i_irq_req <= '0;
		repeat (2) @(posedge i_sys_clk);
		#1;
	endtask : fire
	task automatic drain(int n);
		@(posedge i_sys_clk);
		stall <= 1'b0;
		repeat (n) @(posedge i_sys_clk);
		#1;
		chk("idle", 0, o_cpu_req);
	endtask : drain
	task automatic t_dma();
		int n [4] = '{4, 14, 24, 36};
		for (int i = 0; i < 4; i++) begin
			i_priority_regs[4*n[i] +: 3] = 3'(i + 1);
			fire('0, NIRQ'(1) << n[i], {7'h0, i[0], 8'h0});
			chkv(24'(n[i] + 8), (i[0] ? 24'h00A000 : 24'h0)
				+ 24'h14 + 24'(2 * n[i]), 24'(i + 1));
			chk("dma flag", 1, o_request_flags[n[i]]);
			drain(8);
		end
		$display("dma channels done");
	endtask : t_dma
	task automatic t_trap();
		fire(6'h01, '0, 16'h0100);
		chkv(4, 24'h00A00C, 11);
		chk("math flag", 1, o_intr_ctrl_first[3]);
		chk("trap pending", 24'h10, o_trap_pending);
		drain(8);
		fire(6'h08, '0, 16'h0);
		chkv(2, 24'h8, 13);
		chk("ecc flag", 1, o_intr_ctrl_fourth[1]);
		drain(8);
		fire(6'h04, '0, 16'h0);
		chk("soft flag", 0, o_intr_ctrl_fourth[0]);
		chk("soft ungated", 0, o_cpu_req);
		fire(6'h04, '0, 16'h2000);
		chkv(2, 24'h8, 13);
		chk("soft flag", 1, o_intr_ctrl_fourth[0]);
		drain(8);
		$display("traps done");
	endtask : t_trap
	task automatic t_tie();
		i_priority_regs[20 +: 3] = 3'h5;
		i_priority_regs[56 +: 3] = 3'h5;
		stall = 1'b1;
		fire('0, (NIRQ'(1) << 5) | (NIRQ'(1) << 14), 16'h0);
		chkv(13, 24'h1E, 5);
		fire(6'h01, '0, 16'h0);
		chkv(4, 24'hC, 11);
		drain(20);
		i_request_enable[4] = 1'b0;
		fire('0, (NIRQ'(1) << 21) | (NIRQ'(1) << 4), 16'h0);
		chk("reserved flag", 0, o_request_flags[21]);
		chk("disabled", 0, o_cpu_req);
		@(posedge i_sys_clk);
		i_cpu_prio <= 4'h1;
		i_request_enable[4] <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		#1;
		chk("masked", 0, o_cpu_req);
		@(posedge i_sys_clk);
		i_cpu_prio <= 4'h0;
		drain(8);
		$display("arbitration done");
	endtask : t_tie
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 1000) begin
			bad_count++;
			results();
		end
	end
	initial begin
		repeat (3) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		t_dma();
		t_trap();
		t_tie();
		results();
	end
endmodule : test_trap_and_interrupt_vector_map
